//--- verilog/uart_rx_error_irq_wake.sv
`timescale 1ns/1ps
module uart_rx_error_irq_wake #(
  parameter int depth = 4
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic clk_on,
  input wire logic rx_pin,
  input wire logic [2:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr_stb,
  input wire logic rd_stb,
  input wire logic tx_empty,
  input wire logic tx_idle,
  input wire logic global_int_enable,
  input wire logic uart_int_enable,
  output logic [7:0] rdata,
  output logic uart_irq_n,
  output logic wake_req
);
  // rx synchroniser: change counts when second and third stage agree
  logic [2:0] rx_sync_reg;
  logic rx_level_reg;
  logic rx_prev_reg;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rx_sync_reg <= 3'h7;
      rx_level_reg <= 1'b1;
      rx_prev_reg <= 1'b1;
    end else begin
      rx_sync_reg <= {rx_sync_reg[1:0], rx_pin};
      if (rx_sync_reg[1] == rx_sync_reg[2]) begin
        rx_level_reg <= rx_sync_reg[2];
      end
      rx_prev_reg <= rx_level_reg;
    end
  end
  wire rx_fall = rx_prev_reg & ~rx_level_reg;

  logic [7:0] ctrl_one_reg;
  logic [7:0] ctrl_two_reg;
  logic [7:0] recover_reg;
  logic status_seen_reg;
  // receiver state holds while the uart clock is off; register writes, reads and the wake logic still act
  wire run = clk_on;
  wire rd_status = rd_stb & (addr == uart_rx_pkg::status_offset);
  wire rd_data = rd_stb & (addr == uart_rx_pkg::data_offset);
  wire clear_seq = rd_data & status_seen_reg;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ctrl_one_reg <= uart_rx_pkg::ctrl_reset;
      ctrl_two_reg <= uart_rx_pkg::ctrl_reset;
      recover_reg <= uart_rx_pkg::recover_reset;
    end else if (wr_stb) begin
      case (addr)
        uart_rx_pkg::ctrl_one_offset: ctrl_one_reg <= {wdata[7:2], ctrl_one_reg[1], wdata[0]};
        uart_rx_pkg::ctrl_two_offset: ctrl_two_reg <= wdata;
        uart_rx_pkg::recover_offset: recover_reg <= wdata;
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      status_seen_reg <= 1'b0;
    end else if (rd_status) begin
      status_seen_reg <= 1'b1;
    end else if (rd_data) begin
      status_seen_reg <= 1'b0;
    end
  end

  wire uart_en = ctrl_one_reg[uart_rx_pkg::c1_uart_en];
  wire nine = ctrl_one_reg[uart_rx_pkg::c1_nine];
  wire par_en = ctrl_one_reg[uart_rx_pkg::c1_par_en];
  wire [1:0] par_type = ctrl_one_reg[uart_rx_pkg::c1_par_type +: 2];
  wire two_stop = ctrl_one_reg[uart_rx_pkg::c1_two_stop];
  wire rx_en = ctrl_two_reg[uart_rx_pkg::c2_rx_en];
  wire addr_det = ctrl_two_reg[uart_rx_pkg::c2_addr];
  wire wake_en = ctrl_two_reg[uart_rx_pkg::c2_wake];
  wire rx_int = ctrl_two_reg[uart_rx_pkg::c2_rx_int];

  // wake-up and clock recovery window
  logic [7:0] recover_cnt_reg;
  logic wake_pend_reg;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wake_req <= 1'b0;
      wake_pend_reg <= 1'b0;
      recover_cnt_reg <= 8'h00;
    end else if (!clk_on) begin
      if (rx_fall && wake_en && uart_en && rx_en && rx_int) begin
        wake_req <= 1'b1;
        wake_pend_reg <= 1'b1;
      end
      recover_cnt_reg <= recover_reg;
    end else begin
      wake_req <= 1'b0;
      if (recover_cnt_reg != 8'h00) begin
        recover_cnt_reg <= recover_cnt_reg - 8'h01;
      end else begin
        wake_pend_reg <= 1'b0;
      end
    end
  end
  // rx ignored while recovering
  wire recovering = wake_pend_reg & (recover_cnt_reg != 8'h00);

  // oversampling receiver with 16x tick
  logic [3:0] tick_cnt_reg;
  logic [3:0] phase_reg;
  logic [3:0] bit_cnt_reg;
  logic [8:0] shift_reg;
  logic par_reg;
  logic noise_reg;
  logic stop_bad_reg;
  logic stop_two_reg;
  logic [2:0] maj_reg;
  uart_rx_pkg::rx_state_t state_reg;
  logic done_pulse;
  wire tick = run & (tick_cnt_reg == uart_rx_pkg::oversample);
  // three samples around mid bit, majority decides
  wire [2:0] samp_next = {maj_reg[1:0], rx_level_reg};
  wire maj = (samp_next[0] & samp_next[1]) | (samp_next[1] & samp_next[2])
           | (samp_next[0] & samp_next[2]);
  wire mixed = ~(&samp_next) & (|samp_next);
  wire at_mid = tick & (phase_reg == uart_rx_pkg::mid_sample);
  wire bit_end = tick & (phase_reg == uart_rx_pkg::oversample);
  wire [3:0] nbits = nine ? 4'h9 : 4'h8;
  wire par_calc = (^shift_reg[7:0]) ^ (nine & shift_reg[8]);
  logic par_bad;
  always_comb begin
    case (par_type)
      2'h0: par_bad = par_reg != par_calc;
      2'h1: par_bad = par_reg != ~par_calc;
      2'h2: par_bad = par_reg != 1'b1;
      default: par_bad = par_reg != 1'b0;
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tick_cnt_reg <= 4'h0;
    end else if (run) begin
      tick_cnt_reg <= tick_cnt_reg + 4'h1;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_reg <= uart_rx_pkg::rx_hunt;
      phase_reg <= 4'h0;
      bit_cnt_reg <= 4'h0;
      shift_reg <= 9'h000;
      par_reg <= 1'b0;
      noise_reg <= 1'b0;
      stop_bad_reg <= 1'b0;
      stop_two_reg <= 1'b0;
      maj_reg <= 3'h7;
      done_pulse <= 1'b0;
    end else if (run) begin // frozen while the clock is off
      done_pulse <= 1'b0;
      if (tick) begin
        phase_reg <= phase_reg + 4'h1;
        maj_reg <= samp_next;
      end
      case (state_reg)
        uart_rx_pkg::rx_hunt: begin
          if (tick && uart_en && rx_en && !recovering && !rx_level_reg) begin
            state_reg <= uart_rx_pkg::rx_start;
            phase_reg <= 4'h1;
            noise_reg <= 1'b0;
            stop_bad_reg <= 1'b0;
            stop_two_reg <= 1'b0;
            bit_cnt_reg <= 4'h0;
            shift_reg <= 9'h000;
          end
        end
        uart_rx_pkg::rx_start: begin
          if (at_mid && (maj || mixed)) begin
            state_reg <= uart_rx_pkg::rx_hunt;
          end else if (bit_end) begin
            state_reg <= uart_rx_pkg::rx_data;
          end
        end
        uart_rx_pkg::rx_data: begin
          if (at_mid) begin
            shift_reg <= nine ? {maj, shift_reg[8:1]} : {1'b0, maj, shift_reg[7:1]}; // lsb first
            bit_cnt_reg <= bit_cnt_reg + 4'h1;
            if (mixed) begin
              noise_reg <= 1'b1;
            end
          end
          if (bit_end && bit_cnt_reg == nbits) begin
            state_reg <= par_en ? uart_rx_pkg::rx_parity : uart_rx_pkg::rx_stop;
          end
        end
        uart_rx_pkg::rx_parity: begin
          if (at_mid) begin
            par_reg <= maj;
            if (mixed) begin
              noise_reg <= 1'b1;
            end
          end
          if (bit_end) begin
            state_reg <= uart_rx_pkg::rx_stop;
          end
        end
        uart_rx_pkg::rx_stop: begin
          if (at_mid) begin
            if (!maj) begin
              stop_bad_reg <= 1'b1;
            end
            if (mixed) begin
              noise_reg <= 1'b1;
            end
            if (two_stop && !stop_two_reg) begin
              stop_two_reg <= 1'b1;
            end else begin
              done_pulse <= 1'b1;
              // a low final stop waits for the line to go high; a still-low line is no start
              state_reg <= !maj ? uart_rx_pkg::rx_break : uart_rx_pkg::rx_hunt;
            end
          end
        end
        uart_rx_pkg::rx_break: begin
          if (rx_level_reg) begin
            state_reg <= uart_rx_pkg::rx_hunt;
          end
        end
        default: state_reg <= uart_rx_pkg::rx_hunt;
      endcase
    end
  end

  // fifo holds word, framing and parity alongside each entry
  logic [10:0] fifo_mem [depth];
  logic [$clog2(depth):0] count_reg;
  logic [$clog2(depth)-1:0] wptr_reg;
  logic [$clog2(depth)-1:0] rptr_reg;
  wire full = count_reg == ($clog2(depth)+1)'(depth);
  wire empty = count_reg == '0;
  // done_pulse holds while frozen, so gate it or a stopped clock pushes the word again
  wire done_run = run & done_pulse;
  wire push = done_run & ~full;
  wire pop = clear_seq & ~empty;
  wire par_err_now = par_en & par_bad;
  always_ff @(posedge clk) begin
    if (push) begin
      fifo_mem[wptr_reg] <= {par_err_now, stop_bad_reg, shift_reg};
    end
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      count_reg <= '0;
      wptr_reg <= '0;
      rptr_reg <= '0;
    end else begin
      if (push) begin
        wptr_reg <= wptr_reg + 1'b1;
      end
      if (pop) begin
        rptr_reg <= rptr_reg + 1'b1;
      end
      if (push && !pop) begin
        count_reg <= count_reg + 1'b1;
      end else if (pop && !push) begin
        count_reg <= count_reg - 1'b1;
      end
    end
  end
  wire [10:0] head = fifo_mem[rptr_reg];

  // sticky receive flags, set wins over clear
  logic overrun_flag;
  logic noise_flag;
  logic rx_avail_flag;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      overrun_flag <= 1'b0;
      noise_flag <= 1'b0;
    end else begin
      if (done_run && full) begin
        overrun_flag <= 1'b1; // fifo untouched, shifter reused
      end else if (clear_seq) begin
        overrun_flag <= 1'b0;
      end
      if (push && noise_reg) begin
        noise_flag <= 1'b1;
      end else if (clear_seq) begin
        noise_flag <= 1'b0;
      end
    end
  end
  // available follows fifo occupancy; drops once the last word is taken
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rx_avail_flag <= 1'b0;
    end else begin
      rx_avail_flag <= push | (count_reg > ($clog2(depth)+1)'(pop));
    end
  end
  wire framing_flag = ~empty & head[9];
  wire parity_flag = ~empty & head[10];
  wire rx_idle = (state_reg == uart_rx_pkg::rx_hunt);

  // interrupt conditions
  wire [2:0] trig = ($clog2(depth)+1)'(ctrl_two_reg[uart_rx_pkg::c2_trig +: 2]) + 3'h1;
  wire top_bit = nine ? shift_reg[8] : shift_reg[7];
  wire rx_evt = push & (count_reg + 3'h1 >= trig) & (!addr_det || top_bit);
  wire addr_evt = push & addr_det & top_bit;
  wire over_evt = done_run & full;
  wire rx_group = rx_int & (rx_evt | addr_evt | over_evt);
  wire tx_group = (ctrl_two_reg[uart_rx_pkg::c2_te_int] & tx_empty)
                | (ctrl_two_reg[uart_rx_pkg::c2_ti_int] & tx_idle);
  // wake interrupt delayed until recovery ends, then raised only if the core enables are set in that cycle
  logic wake_irq_due_reg;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wake_irq_due_reg <= 1'b0;
    end else if (wake_pend_reg && clk_on && recover_cnt_reg == 8'h00) begin
      wake_irq_due_reg <= global_int_enable & uart_int_enable;
    end else begin
      wake_irq_due_reg <= 1'b0;
    end
  end
  logic tx_group_prev_reg;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      uart_irq_n <= 1'b1;
      tx_group_prev_reg <= 1'b0;
    end else begin
      // a transmitter edge seen while frozen is held until the clock returns
      if (run) begin
        tx_group_prev_reg <= tx_group;
      end
      // one-cycle low pulse per event
      uart_irq_n <= ~(run & (rx_group | (tx_group & ~tx_group_prev_reg) | wake_irq_due_reg));
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdata <= 8'h00;
    end else if (rd_stb) begin
      case (addr)
        uart_rx_pkg::status_offset: rdata <= {2'h0, rx_idle, rx_avail_flag, framing_flag,
                                              overrun_flag, noise_flag, parity_flag};
        uart_rx_pkg::ctrl_one_offset: rdata <= {ctrl_one_reg[7:2], head[8] & ~empty,
                                                ctrl_one_reg[0]};
        uart_rx_pkg::ctrl_two_offset: rdata <= ctrl_two_reg;
        uart_rx_pkg::data_offset: rdata <= empty ? 8'h00 : head[7:0];
        uart_rx_pkg::count_offset: rdata <= {5'h00, count_reg};
        uart_rx_pkg::recover_offset: rdata <= recover_reg;
        default: rdata <= 8'h00;
      endcase
    end else begin
      rdata <= 8'h00;
    end
  end
endmodule : uart_rx_error_irq_wake

//--- verilog/uart_rx_pkg.sv
// Operation
// - four-byte receive fifo; a fifth byte keeps shifting while the fifo is full.
// - fifth byte completing on full fifo sets overrun, fifo kept, shifter overwritten.
// - overrun raises the uart interrupt only when rx interrupt enable is set.
// - overrun clears only after status read followed by data buffer read.
// - oversampled noise sets noise flag with rx available; word still stored, no interrupt.
// - noise flag clears only after status read followed by data buffer read.
// - framing flag set when a stop bit samples low; both stop bits checked in two-stop mode.
// - framing flag recorded with the received word and cleared by any reset.
// - parity flag set on wrong parity, only when parity is enabled; reset clears it.
// - low pulse requests attention on any of the six uart conditions.
// - transmitter conditions have own enables; three receiver conditions share one.
// - status flags read-only; cleared only by defined access sequences.
// - with address detect, data-available interrupt only when top received bit is high.
// - without address detect, data-available interrupt on each stored word that brings the fifo count to the trigger level or above.
// - address detect interrupt has no flag and needs address detect enabled.
// - clock off with wake, uart, rx and rx interrupt enables set: rx fall wakes.
// - wake-up becomes an interrupt only with global and uart enables set.
// - rx data ignored during clock recovery; wake interrupt delayed until it ends.
// - clock stop freezes transfers and keeps receiver state; register access and wake logic still act.
// - rx available clears after status access followed by a data buffer read that takes the last fifo word.
// - break is a framing error; zeros loaded; wait for valid stop before next start.
package uart_rx_pkg;
  localparam logic [2:0] status_offset = 3'h0;
  localparam logic [2:0] ctrl_one_offset = 3'h1;
  localparam logic [2:0] ctrl_two_offset = 3'h2;
  localparam logic [2:0] data_offset = 3'h3;
  localparam logic [2:0] count_offset = 3'h4;
  localparam logic [2:0] recover_offset = 3'h5;
  // status bit positions
  localparam int st_parity = 0;
  localparam int st_noise = 1;
  localparam int st_overrun = 2;
  localparam int st_framing = 3;
  localparam int st_rx_avail = 4;
  localparam int st_rx_idle = 5;
  // control one: uart enable, nine bit, parity enable, parity type(2), two stop bits
  localparam int c1_uart_en = 7;
  localparam int c1_nine = 6;
  localparam int c1_par_en = 5;
  localparam int c1_par_type = 3;
  localparam int c1_two_stop = 2;
  localparam int c1_rx8 = 1;
  // control two: rx enable, addr detect, wake, rx int, tx empty int, tx idle int, trig level
  localparam int c2_rx_en = 7;
  localparam int c2_addr = 6;
  localparam int c2_wake = 5;
  localparam int c2_rx_int = 4;
  localparam int c2_te_int = 3;
  localparam int c2_ti_int = 2;
  localparam int c2_trig = 0;
  localparam logic [7:0] ctrl_reset = 8'h00;
  localparam logic [15:0] divisor_reset = 16'h000f;
  localparam logic [7:0] recover_reset = 8'h10;
  localparam logic [3:0] oversample = 4'hf;
  localparam logic [3:0] mid_sample = 4'h7;
  localparam int fifo_depth = 4;
  typedef enum logic [2:0] {rx_hunt, rx_start, rx_data, rx_parity, rx_stop, rx_break} rx_state_t;
endpackage : uart_rx_pkg

//--- tb/far_tx.sv
`timescale 1ns/1ps
module far_tx (
  input wire logic clk,
  output logic line
);
  initial line = 1'b1;
  // lsb first; the receiver ticks every sixteen clocks and takes sixteen ticks a bit
  localparam int bit_clocks = 256;
  // glitch_bit flips every sixteen clocks, so tick samples sixteen clocks apart
  // always disagree whatever the receiver's tick phase
  task automatic send(input logic [15:0] bits, input int n, input int glitch_bit);
    for (int i = 0; i < n; i++) begin
      for (int c = 0; c < bit_clocks; c++) begin
        @(posedge clk);
        line <= (i == glitch_bit && c[4]) ? !bits[i] : bits[i];
      end
    end
    @(posedge clk);
    line <= 1'b1;
  endtask : send
endmodule : far_tx

//--- tb/uart_rx_error_irq_wake_properties.sv
`timescale 1ns/1ps
module uart_rx_error_irq_wake_properties #(
  parameter int depth = 4
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic clk_on,
  input wire logic rx_pin,
  input wire logic [2:0] addr,
  input wire logic rd_stb,
  input wire logic [7:0] rdata,
  input wire logic uart_irq_n,
  input wire logic wake_req
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  property p_irq_pulse; $fell(uart_irq_n) |=> uart_irq_n; endproperty
  a_irq_pulse: assert property (p_irq_pulse)
    else $error("irq low longer than one cycle");
  property p_irq_frozen; !clk_on && !$past(clk_on) |-> uart_irq_n; endproperty
  a_irq_frozen: assert property (p_irq_frozen)
    else $error("irq while uart clock stopped");
  property p_wake_rise; $rose(wake_req) |-> !$past(clk_on) && !$past(rx_pin); endproperty
  a_wake_rise: assert property (p_wake_rise)
    else $error("wake without rx fall in clock-off state");
  property p_wake_hold; wake_req && !clk_on |=> wake_req; endproperty
  a_wake_hold: assert property (p_wake_hold)
    else $error("wake dropped while clock off");
  property p_wake_drop; clk_on && $past(clk_on) |-> !wake_req; endproperty
  a_wake_drop: assert property (p_wake_drop)
    else $error("wake held with clock running");
  property p_wake_quiet; $fell(wake_req) |-> uart_irq_n [*8]; endproperty
  a_wake_quiet: assert property (p_wake_quiet)
    else $error("irq inside recovery period");
  property p_read_idle; !$past(rd_stb) |-> rdata == 8'h00; endproperty
  a_read_idle: assert property (p_read_idle)
    else $error("read data outside read reply");
  property p_unmapped; $past(rd_stb) && $past(addr) > 3'h5 |-> rdata == 8'h00; endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped read not zero");
  c_irq: cover property ($fell(uart_irq_n));
  c_wake: cover property ($rose(wake_req));
  c_read: cover property ($past(rd_stb) && rdata != 8'h00);
endmodule : uart_rx_error_irq_wake_properties
bind uart_rx_error_irq_wake uart_rx_error_irq_wake_properties #(.depth(depth)) i_props (
  .clk(clk), .rst(rst), .clk_on(clk_on), .rx_pin(rx_pin), .addr(addr), .rd_stb(rd_stb),
  .rdata(rdata), .uart_irq_n(uart_irq_n), .wake_req(wake_req));

//--- tb/uart_rx_error_irq_wake_tb.sv
`timescale 1ns/1ps
module uart_rx_error_irq_wake_tb;
  localparam logic [2:0] sta = uart_rx_pkg::status_offset;
  localparam logic [2:0] dat = uart_rx_pkg::data_offset;
  localparam logic [2:0] c1 = uart_rx_pkg::ctrl_one_offset;
  localparam logic [2:0] c2 = uart_rx_pkg::ctrl_two_offset;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic clk_on = 1'b1;
  logic [2:0] addr = 3'h0;
  logic [7:0] wdata = 8'h00;
  logic wr_stb = 1'b0;
  logic rd_stb = 1'b0;
  logic tx_empty = 1'b0;
  logic tx_idle = 1'b0;
  logic gie = 1'b0;
  logic uie = 1'b0;
  logic line;
  logic [7:0] rdata;
  logic uart_irq_n;
  logic wake_req;
  logic [7:0] v;
  logic [15:0] fr [3] = '{16'hfcaa, 16'hfaaa, 16'h0000};
  logic [15:0] ad [4] = '{16'hfe24, 16'hff24, 16'hfd00, 16'hfe00};
  int bad_count = 0;
  int checks = 0;
  int irqs = 0;
  int cyc = 0;
  always #20 clk = ~clk;
  far_tx i_far (.clk(clk), .line(line));
  uart_rx_error_irq_wake i_dut (.clk(clk), .rst(rst), .clk_on(clk_on), .rx_pin(line),
    .addr(addr), .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb), .tx_empty(tx_empty),
    .tx_idle(tx_idle), .global_int_enable(gie), .uart_int_enable(uie), .rdata(rdata),
    .uart_irq_n(uart_irq_n), .wake_req(wake_req));
  task automatic stop_test();
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : stop_test
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (!rst && uart_irq_n === 1'b0) irqs <= irqs + 1;
    // about 250 bit times of 256 clocks each, plus register traffic and margin
    if (cyc == 80000) begin
      bad_count = bad_count + 1;
      stop_test();
    end
  end
  task automatic chk(input string n, input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", n, exp, seen);
    end
  endtask : chk
  task automatic idle(input int n);
    repeat (n) @(posedge clk);
  endtask : idle
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr_stb <= 1'b1;
    @(posedge clk);
    wr_stb <= 1'b0;
  endtask : wr
  task automatic rd(input logic [2:0] a);
    @(posedge clk);
    addr <= a;
    rd_stb <= 1'b1;
    @(posedge clk);
    rd_stb <= 1'b0;
    // read data stands only in the cycle after the strobe; take it at the edge ending it
    @(posedge clk);
    v = rdata;
  endtask : rd
  task automatic tx(input logic [15:0] b, input int n, input int g);
    i_far.send(b, n, g);
    idle(40);
  endtask : tx
  // status always read before the word it describes
  task automatic take(input logic [7:0] s, input logic [7:0] d);
    rd(sta);
    chk("status", v, s);
    rd(dat);
    chk("data", v, d);
  endtask : take
  task automatic done(input string n);
    $display("test %s finished", n);
  endtask : done
  initial begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    rd(sta);
    chk("reset status", v, 8'h20);
    rd(uart_rx_pkg::recover_offset);
    chk("recovery", v, 8'h10);
    rd(3'h7);
    chk("unmapped", v, 8'h00);
    wr(sta, 8'hff);
    rd(sta);
    chk("status write", v, 8'h20);
    wr(c1, 8'h80);
    wr(c2, 8'h90);
    irqs = 0;
    tx({7'h7f, 8'h25, 1'b0}, 10, 99);
    chk("data irq", 8'(irqs), 8'h01);
    take(8'h30, 8'h25);
    done("basic");
    // trigger at four entries so only the full fifo and the overrun pulse
    wr(c2, 8'h93);
    irqs = 0;
    for (int k = 1; k <= 5; k++) tx({7'h7f, 8'(k * 17), 1'b0}, 10, 99);
    chk("overrun irqs", 8'(irqs), 8'h02);
    rd(uart_rx_pkg::count_offset);
    chk("fifo count", v, 8'h04);
    take(8'h34, 8'h11);
    for (int k = 2; k <= 4; k++) take(8'h30, 8'(k * 17));
    wr(c2, 8'h90);
    done("overrun");
    for (int j = 0; j < 3; j++) begin
      wr(c1, j == 1 ? 8'h84 : 8'h80);
      tx(fr[j], j == 2 ? 14 : 11, 99);
      take(8'h38, j == 2 ? 8'h00 : 8'h55);
    end
    done("framing");
    for (int t = 0; t < 8; t++) begin
      wr(c1, {3'b101, t[2:1], 3'b000});
      tx({6'h3f, t[1] ~^ t[0], 8'h01, 1'b0}, 11, 99);
      take({7'h18, t[0]}, 8'h01);
    end
    done("parity");
    wr(c1, 8'h80);
    irqs = 0;
    tx({7'h7f, 8'h00, 1'b0}, 10, 1);
    chk("noise irqs", 8'(irqs), 8'h01);
    rd(sta);
    chk("noise", v, 8'h32);
    rd(dat);
    rd(sta);
    chk("noise cleared", v, 8'h20);
    done("noise");
    // parity stays off while address detect is on
    wr(c2, 8'hd0);
    for (int j = 0; j < 4; j++) begin
      wr(c1, j < 2 ? 8'h80 : 8'hc0);
      irqs = 0;
      tx(ad[j], j < 2 ? 10 : 11, 99);
      chk("address irq", 8'(irqs), 8'(j % 2));
      take(8'h30, ad[j][8:1]);
    end
    done("address");
    wr(c1, 8'h80);
    wr(c2, 8'h88);
    irqs = 0;
    tx({7'h7f, 8'h77, 1'b0}, 10, 99);
    take(8'h30, 8'h77);
    tx_idle <= 1'b1;
    idle(4);
    chk("masked irqs", 8'(irqs), 8'h00);
    tx_empty <= 1'b1;
    idle(4);
    chk("empty irq", 8'(irqs), 8'h01);
    tx_empty <= 1'b0;
    tx_idle <= 1'b0;
    wr(c2, 8'h84);
    tx_idle <= 1'b1;
    idle(4);
    chk("idle irq", 8'(irqs), 8'h02);
    done("transmit");
    wr(c2, 8'hb0);
    for (int j = 0; j < 2; j++) begin
      gie <= j[0];
      uie <= j[0];
      irqs = 0;
      // the line is quiet before the clock is stopped
      clk_on <= 1'b0;
      idle(4);
      i_far.send(16'h0000, 1, 99);
      idle(4);
      chk("wake", {7'h00, wake_req}, 8'h01);
      clk_on <= 1'b1;
      idle(60);
      chk("wake irq", 8'(irqs), 8'(j));
      rd(uart_rx_pkg::count_offset);
      chk("ignored", v, 8'h00);
    end
    done("wake");
    stop_test();
  end
endmodule : uart_rx_error_irq_wake_tb
